// *** logic/trc_alu.sv ***
// Eight-bit arithmetic and logic unit with carry and nibble carry
`timescale 1ns/1ps
`default_nettype none

module trc_alu (
  trc_alu_if.alu bus
);
  import trc_pkg::*;

  logic sub;
  logic [7:0] addend;
  logic [8:0] sum;
  logic [4:0] nib;

  always_comb begin
    // Subtract as x + ~w + 1 so carry out reads as no-borrow [RULE9]
    sub = (bus.op == OP_SUB);
    addend = sub ? ~bus.w : bus.w;
    sum = {1'b0, bus.x} + {1'b0, addend} + {8'h00, sub}; // [RULE19]
    nib = {1'b0, bus.x[3:0]} + {1'b0, addend[3:0]} + {4'h0, sub};
    bus.co = sum[8]; // [RULE14]
    bus.nwo = nib[4]; // [RULE14]
    case (bus.op) // [RULE8]
      OP_ADD, OP_SUB: bus.y = sum[7:0];
      OP_AND: bus.y = bus.x & bus.w;
      OP_OR: bus.y = bus.x | bus.w;
      OP_XOR: bus.y = bus.x ^ bus.w;
      OP_COM: bus.y = ~bus.x;
      OP_INC, OP_INCSZ: bus.y = bus.x + 8'h01;
      OP_DEC, OP_DECSZ: bus.y = bus.x - 8'h01;
      OP_RLC: begin
        bus.y = {bus.x[6:0], bus.cin};
        bus.co = bus.x[7];
      end
      OP_RRC: begin
        bus.y = {bus.cin, bus.x[7:1]};
        bus.co = bus.x[0];
      end
      OP_SWAP: bus.y = {bus.x[3:0], bus.x[7:4]};
      OP_CLR: bus.y = 8'h00;
      OP_PASS_A: bus.y = bus.w;
      default: bus.y = bus.x;
    endcase
  end
endmodule // trc_alu

`default_nettype wire

// *** logic/trc_core.sv ***
// Two-stage pipelined datapath of the tiny RISC core
`timescale 1ns/1ps
`default_nettype none
`include "trc_defs.svh"

// What this block does
// RULE1: Each instruction is one twelve-bit word
// RULE2: Fetch one whole twelve-bit word per cycle
// RULE3: Separate program bus and eight-bit data path
// RULE4: Next fetch overlaps current execution
// RULE5: Non-branch instructions finish in one cycle
// RULE6: Special registers and PC sit in data space
// RULE7: Direct and indirect file addressing
// RULE8: Eight-bit add, subtract, shift, logic unit
// RULE9: Arithmetic is two's complement
// RULE10: Two operands: accumulator with file or literal
// RULE11: Single operand: accumulator or file register
// RULE12: Accumulator has no data address
// RULE13: Carry, nibble carry, zero flags updated per op
// RULE14: Subtraction carries read as borrow-out, inverted
// RULE15: PC-changing instructions take two cycles
// RULE16: Clock divided by four, PC steps in phase one
// RULE17: Operand read phase two, write phase four
// RULE18: Zero flag set exactly for zero result
// RULE19: Carry from bit seven, nibble from bit three
module trc_core #(
  parameter int PC_W = 9
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  input wire logic [`TRC_IW-1:0] i_pm_data,
  output logic [PC_W-1:0] o_pm_addr,
  output logic [`TRC_DW-1:0] o_acc,
  output logic [`TRC_DW-1:0] o_status,
  output logic [1:0] o_phase
);
  import trc_pkg::*;

  // Data memory entries above the special registers
  localparam int RAM_N = (1 << `TRC_AW) - int'(`TRC_A_GPR);
  // One instruction cycle in ns, four clock periods
  localparam int CYCLE_NS = `TRC_CYCLE_NS;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] faddr;
    logic [`TRC_IW-1:0] fetch;
    logic fval;
    logic [`TRC_IW-1:0] ir;
    logic ival;
    logic [7:0] opnd;
    logic [7:0] acc;
    logic [7:0] fsr;
    logic c;
    logic nw;
    logic z;
    logic [RAM_N-1:0][7:0] ram;
  } trc_core_s;

  trc_core_s st;
  trc_core_s next_st;

  trc_phase_if ph_if ();
  trc_alu_if alu_if ();

  trc_phase u_phase (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .ph(ph_if.gen)
  );

  trc_alu u_alu (
    .bus(alu_if.alu)
  );

  logic [1:0] ph;
  logic is_lit;
  logic is_jump;
  logic is_file;
  logic dest_file;
  logic [`TRC_AW-1:0] faddr5;
  logic [`TRC_AW-1:0] ea;
  logic [`TRC_AW-1:0] gi;
  logic [7:0] status_byte;
  logic [7:0] rdata;
  trc_aluop_e op;
  logic c_en;
  logic nw_en;
  logic z_en;
  logic skip_hit;
  logic branch;
  logic [PC_W-1:0] target;

  assign ph = ph_if.phase;

  // Decode of the single-word instruction [RULE1]
  assign is_lit = st.ir[`TRC_LIT_BIT];
  assign is_jump = !is_lit && st.ir[`TRC_JMP_BIT];
  assign is_file = !is_lit && !st.ir[`TRC_JMP_BIT];
  assign dest_file = is_file && st.ir[`TRC_DEST_BIT];
  assign faddr5 = st.ir[`TRC_F_HI:0];
  assign target = st.ir[PC_W-1:0];

  // Indirect access goes through the select register [RULE7]
  assign ea = (faddr5 == `TRC_A_INDF) ? st.fsr[`TRC_AW-1:0] : faddr5;
  assign gi = ea - `TRC_A_GPR;

  always_comb begin
    status_byte = 8'h00;
    status_byte[`TRC_ST_C] = st.c;
    status_byte[`TRC_ST_NW] = st.nw;
    status_byte[`TRC_ST_Z] = st.z;
  end

  // Special registers answer in data space; the accumulator does not
  // appear here at all, so file addressing cannot reach it [RULE6] [RULE12]
  always_comb begin
    if (ea == `TRC_A_PCL) begin
      rdata = st.faddr[7:0];
    end else if (ea == `TRC_A_STATUS) begin
      rdata = status_byte;
    end else if (ea == `TRC_A_FSR) begin
      rdata = st.fsr;
    end else if (ea >= `TRC_A_GPR) begin
      rdata = st.ram[gi];
    end else begin
      rdata = 8'h00;
    end
  end

  // Literal ops reuse the first eight codes of the file ops [RULE10]
  assign op = is_lit ? trc_aluop_e'({1'b0, st.ir[`TRC_LOP_HI:`TRC_LOP_LO]})
                     : trc_aluop_e'(st.ir[`TRC_OP_HI:`TRC_OP_LO]);

  assign alu_if.op = op;
  assign alu_if.x = is_lit ? st.ir[`TRC_K_HI:0] : st.opnd; // [RULE10] [RULE11]
  assign alu_if.w = st.acc;
  assign alu_if.cin = st.c;

  // Flag selection per operation [RULE13]
  always_comb begin
    c_en = (op == OP_ADD) || (op == OP_SUB);
    nw_en = c_en;
    z_en = !is_jump;
    case (op)
      OP_RLC, OP_RRC: begin
        c_en = !is_lit;
        z_en = 1'b0;
      end
      OP_PASS_A, OP_SWAP, OP_INCSZ, OP_DECSZ: z_en = 1'b0;
      OP_PASS_F: z_en = !is_lit && !is_jump;
      default: ;
    endcase
  end

  assign skip_hit = is_file && ((op == OP_INCSZ) || (op == OP_DECSZ)) &&
                    (alu_if.y == 8'h00);
  // Any change of flow flushes the word fetched alongside [RULE15]
  assign branch = st.ival &&
                  (is_jump || skip_hit || (dest_file && ea == `TRC_A_PCL));

  always_comb begin
    next_st = st;
    case (ph)
      `TRC_PH_ONE: begin
        // Fetch address steps in phase one; the fetched word enters
        // execution at the same time [RULE16] [RULE4]
        next_st.faddr = st.pc;
        next_st.pc = st.pc + 1'b1;
        next_st.ir = st.fetch;
        next_st.ival = st.fval;
      end
      `TRC_PH_TWO: begin
        if (st.ival) begin
          next_st.opnd = rdata; // [RULE17]
        end
      end
      `TRC_PH_FOUR: begin
        // Program bus is separate from the data path [RULE2] [RULE3]
        next_st.fetch = i_pm_data;
        next_st.fval = !branch; // [RULE5] [RULE15]
        if (st.ival) begin
          if (is_jump) begin
            next_st.pc = target; // [RULE15]
          end else if (dest_file) begin
            case (ea) // [RULE17]
              `TRC_A_PCL: next_st.pc = {{(PC_W-8){1'b0}}, alu_if.y}; // [RULE6]
              `TRC_A_STATUS: begin
                next_st.c = alu_if.y[`TRC_ST_C];
                next_st.nw = alu_if.y[`TRC_ST_NW];
                next_st.z = alu_if.y[`TRC_ST_Z];
              end
              `TRC_A_FSR: next_st.fsr = alu_if.y;
              default: begin
                if (ea >= `TRC_A_GPR) begin
                  next_st.ram[gi] = alu_if.y;
                end
              end
            endcase
          end else begin
            next_st.acc = alu_if.y; // [RULE12]
          end
          // Flag updates win over a direct write to the status register
          if (c_en) begin
            next_st.c = alu_if.co; // [RULE13] [RULE14] [RULE19]
          end
          if (nw_en) begin
            next_st.nw = alu_if.nwo; // [RULE14] [RULE19]
          end
          if (z_en) begin
            next_st.z = (alu_if.y == 8'h00); // [RULE18]
          end
        end
      end
      default: ;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_pm_addr = st.faddr;
  assign o_acc = st.acc;
  assign o_status = status_byte;
  assign o_phase = ph;

  // Reference sums kept apart from the arithmetic unit
  logic [8:0] ref_add;
  assign ref_add = {1'b0, alu_if.x} + {1'b0, st.acc};
  logic q4_exec;
  assign q4_exec = i_ce && (ph == `TRC_PH_FOUR) && st.ival;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  a_fetch_word: assert property (i_ce && ph == `TRC_PH_FOUR |=> // [RULE2]
    st.fetch == $past(i_pm_data))
    else $error("fetch word not taken whole in phase four");

  a_ir_whole: assert property (i_ce && ph == `TRC_PH_ONE |=> // [RULE1]
    st.ir == $past(st.fetch) && st.ival == $past(st.fval))
    else $error("instruction register not loaded from fetch");

  a_fetch_overlap: assert property (!$stable(o_pm_addr) |-> // [RULE4]
    $past(ph) == `TRC_PH_ONE && $past(i_ce))
    else $error("fetch address moved outside phase one");

  a_phase_wrap: assert property (i_ce && ph == `TRC_PH_FOUR |=> // [RULE16]
    ph == `TRC_PH_ONE)
    else $error("phase did not wrap after phase four");

  a_pc_step: assert property (i_ce && ph == `TRC_PH_ONE |=> // [RULE16]
    st.pc == PC_W'($past(st.pc) + 1'b1) && st.faddr == $past(st.pc))
    else $error("program counter did not step in phase one");

  a_operand_q2: assert property (!$stable(st.opnd) |-> // [RULE17]
    $past(ph) == `TRC_PH_TWO)
    else $error("operand latched outside phase two");

  a_write_q4: assert property ( // [RULE17]
    !$stable(st.acc) || !$stable(st.ram) || !$stable(st.fsr) |->
    $past(ph) == `TRC_PH_FOUR && $past(st.ival))
    else $error("destination written outside phase four");

  a_zero_flag: assert property (q4_exec && z_en |=> // [RULE18]
    st.z == ($past(alu_if.y) == 8'h00))
    else $error("zero flag does not match result");

  a_add_carry: assert property (q4_exec && op == OP_ADD |=> // [RULE19]
    st.c == $past(ref_add[8]) &&
    (st.acc == $past(ref_add[7:0]) || $past(dest_file)))
    else $error("add carry or sum wrong");

  // An instruction with a file destination, or a jump, must leave the hidden accumulator alone
  a_acc_kept: assert property ( // [RULE12]
    q4_exec && (dest_file || is_jump) |=> $stable(st.acc))
    else $error("accumulator written by a file or jump instruction");

  a_sub_borrow: assert property (q4_exec && op == OP_SUB |=> // [RULE14]
    st.c == ($past(alu_if.x) >= $past(st.acc)) &&
    st.nw == ($past(alu_if.x[3:0]) >= $past(st.acc[3:0])))
    else $error("subtract borrow flags wrong");

  a_branch_flush: assert property ( // [RULE15]
    i_ce && ph == `TRC_PH_FOUR && branch |=>
    !st.fval ##1 (!st.ival || !$past(i_ce)))
    else $error("branch did not flush the fetched word");

  a_single_cycle: assert property ( // [RULE5]
    i_ce && ph == `TRC_PH_FOUR && !branch |=> st.fval)
    else $error("plain instruction stalled the pipeline");

  c_jump: cover property (q4_exec && is_jump);
  c_skip: cover property (q4_exec && skip_hit);
  c_indirect: cover property (q4_exec && dest_file && faddr5 == `TRC_A_INDF);
  c_pcl_write: cover property (q4_exec && dest_file && ea == `TRC_A_PCL);
endmodule // trc_core

`default_nettype wire

// *** logic/trc_phase.sv ***
// Divides the clock into four phases per instruction cycle
`timescale 1ns/1ps
`default_nettype none
`include "trc_defs.svh"

module trc_phase (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  trc_phase_if.gen ph
);
  import trc_pkg::*;

  typedef struct packed {
    logic [1:0] phase;
  } trc_phase_s;

  trc_phase_s st;
  trc_phase_s next_st;

  always_comb begin
    next_st = st;
    // Wraps after phase four, giving a divide by four [RULE16]
    next_st.phase = st.phase + 2'h1;
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign ph.phase = st.phase;
endmodule // trc_phase

`default_nettype wire

// *** pkg/trc_defs.svh ***
// Constants shared by the tiny RISC core datapath files
`ifndef TRC_DEFS_SVH
`define TRC_DEFS_SVH

`define TRC_IW 12
`define TRC_DW 8
`define TRC_AW 5
`define TRC_CLK_PERIOD_NS 50
`define TRC_PHASES 4
`define TRC_CYCLE_NS (`TRC_PHASES * `TRC_CLK_PERIOD_NS)

`define TRC_PH_ONE 2'h0
`define TRC_PH_TWO 2'h1
`define TRC_PH_THREE 2'h2
`define TRC_PH_FOUR 2'h3

`define TRC_A_INDF 5'h00
`define TRC_A_PCL 5'h02
`define TRC_A_STATUS 5'h03
`define TRC_A_FSR 5'h04
`define TRC_A_GPR 5'h05

`define TRC_ST_C 0
`define TRC_ST_NW 1
`define TRC_ST_Z 2

`define TRC_LIT_BIT 11
`define TRC_JMP_BIT 10
`define TRC_OP_HI 9
`define TRC_OP_LO 6
`define TRC_LOP_HI 10
`define TRC_LOP_LO 8
`define TRC_DEST_BIT 5
`define TRC_K_HI 7
`define TRC_F_HI 4

`endif

// *** pkg/trc_if.sv ***
// Interfaces between the core and its phase and arithmetic units
`timescale 1ns/1ps
`default_nettype none

interface trc_phase_if;
  logic [1:0] phase;
  modport gen (output phase);
  modport use_ph (input phase);
endinterface

interface trc_alu_if;
  trc_pkg::trc_aluop_e op;
  logic [7:0] x;
  logic [7:0] w;
  logic cin;
  logic [7:0] y;
  logic co;
  logic nwo;
  modport core (output op, x, w, cin, input y, co, nwo);
  modport alu (input op, x, w, cin, output y, co, nwo);
endinterface

`default_nettype wire

// *** pkg/trc_pkg.sv ***
// Types shared by the tiny RISC core datapath files
package trc_pkg;

  typedef enum logic [3:0] {
    OP_PASS_F, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_COM, OP_INC,
    OP_DEC, OP_RLC, OP_RRC, OP_SWAP, OP_CLR, OP_PASS_A, OP_INCSZ, OP_DECSZ
  } trc_aluop_e;

endpackage

// *** verification/tb_top.sv ***
// Self-checking bench for the tiny RISC core datapath
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct packed {
    logic [11:0] ins;
    logic [7:0] acc;
    logic [7:0] st;
  } trc_row_s;
  localparam int N = 37;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_ce = 1'b1;
  logic [11:0] pm_data;
  logic [8:0] pm_addr;
  logic [7:0] acc;
  logic [7:0] status;
  logic [1:0] phase;
  int failures = 0;
  int samples_checked = 0;
  // Row i sits at address i; accumulator and status after it executes
  trc_row_s rows [N] = '{
    '{12'h8ff, 8'hff, 8'h00}, '{12'h901, 8'h00, 8'h07},
    '{12'h80f, 8'h0f, 8'h07}, '{12'h901, 8'h10, 8'h02},
    '{12'ha05, 8'hf5, 8'h02}, '{12'haf5, 8'h00, 8'h07},
    '{12'h87f, 8'h7f, 8'h07}, '{12'h901, 8'h80, 8'h02},
    '{12'hb0f, 8'h00, 8'h06}, '{12'hca5, 8'ha5, 8'h02},
    '{12'hd5a, 8'hff, 8'h02}, '{12'hdff, 8'h00, 8'h06},
    '{12'he00, 8'hff, 8'h02}, '{12'hf7f, 8'h80, 8'h02},
    '{12'h365, 8'h80, 8'h02}, '{12'h811, 8'h11, 8'h02},
    '{12'h005, 8'h80, 8'h02}, '{12'h045, 8'h00, 8'h05},
    '{12'h1e5, 8'h00, 8'h01}, '{12'h005, 8'h81, 8'h01},
    '{12'h245, 8'h03, 8'h01}, '{12'h285, 8'hc0, 8'h01},
    '{12'h2c5, 8'h18, 8'h01}, '{12'h305, 8'h00, 8'h05},
    '{12'h205, 8'h80, 8'h01}, '{12'h185, 8'h7e, 8'h01},
    '{12'h085, 8'h03, 8'h01}, '{12'h0c5, 8'h01, 8'h01},
    '{12'h105, 8'h81, 8'h01}, '{12'h145, 8'h00, 8'h05},
    '{12'h805, 8'h05, 8'h05}, '{12'h364, 8'h05, 8'h05},
    '{12'h800, 8'h00, 8'h05}, '{12'h000, 8'h81, 8'h01},
    '{12'h003, 8'h01, 8'h01}, '{12'h3e5, 8'h01, 8'h01},
    '{12'h005, 8'h80, 8'h01}
  };
  localparam int NW = 17;
  localparam int NC = 18;
  // Jump, flushed word, program counter read, a taken skip, an indirect
  // write read back directly, and a write to the program counter
  logic [8:0] br_a [NW] = '{9'h000, 9'h001, 9'h002, 9'h006, 9'h007,
    9'h008, 9'h009, 9'h00a, 9'h00b, 9'h00c, 9'h00d, 9'h00e, 9'h00f,
    9'h010, 9'h011, 9'h012, 9'h015};
  logic [11:0] br_w [NW] = '{12'h833, 12'h406, 12'h8ee, 12'h002, 12'h8ff,
    12'h365, 12'h385, 12'h8ee, 12'h844, 12'h806, 12'h364, 12'h360,
    12'h800, 12'h006, 12'h815, 12'h362, 12'h8aa};
  // One entry per instruction cycle, flushed cycles included
  logic [7:0] br_acc [NC] = '{8'h33, 8'h33, 8'h33, 8'h07, 8'hff, 8'hff,
    8'h00, 8'h00, 8'h44, 8'h06, 8'h06, 8'h06, 8'h00, 8'h06, 8'h15,
    8'h15, 8'h15, 8'haa};
  logic [8:0] br_pc [NC] = '{9'h001, 9'h002, 9'h006, 9'h007, 9'h008,
    9'h009, 9'h00a, 9'h00b, 9'h00c, 9'h00d, 9'h00e, 9'h00f, 9'h010,
    9'h011, 9'h012, 9'h013, 9'h015, 9'h016};

  always #25 i_clk = ~i_clk;

  trc_prog_rom #(.AW(9)) u_trc_prog_rom (
    .i_addr(pm_addr),
    .o_data(pm_data)
  );

  trc_core #(.PC_W(9)) u_trc_core (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_ce(i_ce),
    .i_pm_data(pm_data),
    .o_pm_addr(pm_addr),
    .o_acc(acc),
    .o_status(status),
    .o_phase(phase)
  );

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic check_idle();
    check(12'(acc), 12'h000);
    check(12'(status), 12'h000);
    check(12'(pm_addr), 12'h000);
    check(12'(phase), 12'h000);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hung run short
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end

  initial begin
    // Loading after time zero keeps the memory's own clearing from racing
    repeat (6) @(negedge i_clk);
    for (int i = 0; i < N; i++) begin
      u_trc_prog_rom.put(9'(i), rows[i].ins);
    end
    check_idle();
    i_nrst = 1'b1;
    for (int p = 1; p <= 4; p++) begin
      @(negedge i_clk);
      check(12'(phase), 12'(p % 4));
    end
    for (int i = 0; i < N; i++) begin
      repeat (4) @(negedge i_clk);
      check(12'(acc), 12'(rows[i].acc));
      check(12'(status), 12'(rows[i].st));
      check(12'(pm_addr), 12'(i + 1));
    end
    // With the clock enable low nothing may move, not even the phase
    i_ce = 1'b0;
    repeat (5) @(negedge i_clk);
    check(12'(phase), 12'h000);
    check(12'(acc), 12'(rows[N-1].acc));
    i_ce = 1'b1;
    @(negedge i_clk);
    i_nrst = 1'b0;
    repeat (6) @(negedge i_clk);
    check_idle();
    for (int i = 0; i < NW; i++) begin
      u_trc_prog_rom.put(br_a[i], br_w[i]);
    end
    i_nrst = 1'b1;
    repeat (4) @(negedge i_clk);
    for (int c = 0; c < NC; c++) begin
      repeat (4) @(negedge i_clk);
      check(12'(acc), 12'(br_acc[c]));
      check(12'(pm_addr), 12'(br_pc[c]));
    end
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire

// *** verification/trc_prog_rom.sv ***
// Program memory model that feeds instruction words to the core
`timescale 1ns/1ps
`default_nettype none
`include "trc_defs.svh"

module trc_prog_rom #(
  parameter int AW = 9
) (
  input wire logic [AW-1:0] i_addr,
  output logic [`TRC_IW-1:0] o_data
);
  logic [`TRC_IW-1:0] mem [0:(1<<AW)-1];

  // Combinational read, so the word is settled long before phase four
  // A continuous read also follows words loaded while the address stands
  assign o_data = mem[i_addr];

  task automatic put(input logic [AW-1:0] a, input logic [`TRC_IW-1:0] w);
    mem[a] = w;
  endtask

  initial begin
    for (int i = 0; i < (1 << AW); i++) begin
      mem[i] = 12'h000;
    end
  end
endmodule // trc_prog_rom

`default_nettype wire
